// file: rtl/bcce_core.sv
// Purpose: Execute the zero branch, overflow branch, call and clear instructions.
// Assumes: The fetch unit shows the word at pc_o on instr_word_i in Q1 and the next word on call_word2_i in Q4.
// Notes: Other opcodes only advance the counter; the ALU lives elsewhere.
`timescale 1ns/1ps
module bcce_core
  import bcce_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Program memory side.
  input wire logic [15:0] instr_word_i,
  input wire logic [15:0] call_word2_i,
  output logic [PC_W-1:0] pc_o,
  output logic [1:0] quarter_o,
  // Core state inputs.
  input wire logic zero_flag_i,
  input wire logic overflow_flag_i,
  input wire logic [7:0] working_i,
  input wire logic [7:0] status_i,
  input wire logic [7:0] bank_select_register_i,
  input wire logic extended_set_i,
  input wire logic [DADDR_W-1:0] index_base_i,
  // Return stack.
  output logic stack_push_o,
  output logic [PC_W-1:0] top_of_stack_o,
  // Shadow copies.
  output logic [7:0] working_shadow_o,
  output logic [7:0] status_shadow_o,
  output logic [7:0] bank_select_shadow_o,
  // Data memory and status update.
  output logic data_rd_o,
  output logic data_wr_o,
  output logic [DADDR_W-1:0] data_addr_o,
  output logic [7:0] data_wdata_o,
  output logic zero_set_o,
  output logic indexed_mode_o
);
  logic [1:0] quarter; // Current quarter phase.
  bcce_state_t state_r, state_nxt; // Run or discarded second cycle.
  bcce_op_t op_r, op_nxt; // Decoded operation of this cycle.
  logic [15:0] instr_r, instr_nxt; // Latched instruction word.
  logic [PC_W-1:0] iaddr_r, iaddr_nxt; // Address of the current instruction.
  logic [PC_W-1:0] pc_r, pc_nxt; // Program counter.
  logic [PC_W-1:0] ret_top_r, ret_top_nxt; // Last pushed return address.
  logic push_r, push_nxt; // Push strobe.
  logic [7:0] wsh_r, wsh_nxt; // Working shadow.
  logic [7:0] ss_r, ss_nxt; // Status shadow.
  logic [7:0] bs_r, bs_nxt; // Bank select shadow.
  logic rd_r, rd_nxt; // Data read strobe.
  logic wr_r, wr_nxt; // Data write strobe.
  logic [DADDR_W-1:0] addr_r, addr_nxt; // Data address.
  logic zset_r, zset_nxt; // Zero flag set strobe.
  logic idx_r, idx_nxt; // Indexed operand flag.
  logic taken_r, taken_nxt; // Branch condition held from Q3.
  bcce_op_t dec_op; // Decode of the incoming word.
  logic [PC_W-1:0] br_offset; // Doubled sign-extended offset.
  logic [7:0] faddr; // Register address field.

  // Quarter phase source.
  bcce_qphase u_qphase (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .quarter_o(quarter)
  );

  // Decode the word shown in Q1.
  always_comb begin
    if (instr_word_i[15:8] == OPC_BRANCH_ZERO) begin
      dec_op = OP_BRZ;
    end else if (instr_word_i[15:8] == OPC_BRANCH_OVF) begin
      dec_op = OP_BROV;
    end else if (instr_word_i[15:9] == OPC_CALL) begin
      dec_op = OP_CALL;
    end else if (instr_word_i[15:9] == OPC_CLEAR) begin
      dec_op = OP_CLEAR;
    end else begin
      dec_op = OP_OTHER;
    end
  end

  // The counter has not moved past the word yet, hence the plus two in the target.
  assign br_offset = {{12{instr_r[7]}}, instr_r[7:0], 1'b0};
  assign faddr = instr_r[7:0];

  // Next state of the sequencer; strobes default low so each lasts one quarter.
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    instr_nxt = instr_r;
    iaddr_nxt = iaddr_r;
    pc_nxt = pc_r;
    ret_top_nxt = ret_top_r;
    push_nxt = 1'b0;
    wsh_nxt = wsh_r;
    ss_nxt = ss_r;
    bs_nxt = bs_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    addr_nxt = addr_r;
    zset_nxt = 1'b0;
    idx_nxt = idx_r;
    taken_nxt = taken_r;
    case (quarter)
      Q1: begin
        // A discarded cycle decodes nothing, so a stale word cannot act.
        if (state_r == ST_RUN) begin
          op_nxt = dec_op;
          instr_nxt = instr_word_i;
          iaddr_nxt = pc_r;
        end else begin
          op_nxt = OP_OTHER;
        end
        taken_nxt = 1'b0;
      end
      Q2: begin
        if (op_r == OP_CLEAR) begin
          rd_nxt = 1'b1;
          idx_nxt = 1'b0;
          if (!instr_r[ACCESS_BIT]) begin
            if (extended_set_i && (faddr <= INDEXED_MAX)) begin
              addr_nxt = index_base_i + {4'h0, faddr};
              idx_nxt = 1'b1;
            end else if (faddr < ACCESS_SPLIT) begin
              addr_nxt = {4'h0, faddr};
            end else begin
              addr_nxt = {ACCESS_HIGH_BANK, faddr};
            end
          end else begin
            addr_nxt = {bank_select_register_i[3:0], faddr};
          end
        end
      end
      Q3: begin
        // Flags are sampled once so a flag change in Q4 cannot split the decision.
        if (op_r == OP_BRZ) begin
          taken_nxt = zero_flag_i;
        end else if (op_r == OP_BROV) begin
          taken_nxt = overflow_flag_i;
        end
        if (op_r == OP_CALL) begin
          ret_top_nxt = iaddr_r + CALL_RET_STEP;
          push_nxt = 1'b1;
          if (instr_r[SHADOW_BIT]) begin
            wsh_nxt = working_i;
            ss_nxt = status_i;
            bs_nxt = bank_select_register_i;
          end
        end
      end
      Q4: begin
        state_nxt = ST_RUN;
        if (state_r == ST_NOP) begin
          pc_nxt = pc_r;
        end else begin
          case (op_r)
            OP_BRZ, OP_BROV: begin
              if (taken_r) begin
                pc_nxt = iaddr_r + PC_STEP + br_offset;
                state_nxt = ST_NOP;
              end else begin
                pc_nxt = pc_r + PC_STEP;
              end
            end
            OP_CALL: begin
              // The second word is taken here; a word without the F prefix is still used.
              pc_nxt = {call_word2_i[11:0], instr_r[7:0], 1'b0};
              state_nxt = ST_NOP;
            end
            OP_CLEAR: begin
              wr_nxt = 1'b1;
              zset_nxt = 1'b1;
              pc_nxt = pc_r + PC_STEP;
            end
            default: begin
              pc_nxt = pc_r + PC_STEP;
            end
          endcase
        end
      end
      default: begin
        state_nxt = state_r;
      end
    endcase
  end

  // Register all sequencer state.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_r <= ST_RUN;
      op_r <= OP_OTHER;
      instr_r <= 16'h0000;
      iaddr_r <= PC_RESET;
      pc_r <= PC_RESET;
      ret_top_r <= PC_RESET;
      push_r <= 1'b0;
      wsh_r <= 8'h00;
      ss_r <= 8'h00;
      bs_r <= 8'h00;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= 12'h000;
      zset_r <= 1'b0;
      idx_r <= 1'b0;
      taken_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      instr_r <= instr_nxt;
      iaddr_r <= iaddr_nxt;
      pc_r <= pc_nxt;
      ret_top_r <= ret_top_nxt;
      push_r <= push_nxt;
      wsh_r <= wsh_nxt;
      ss_r <= ss_nxt;
      bs_r <= bs_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      zset_r <= zset_nxt;
      idx_r <= idx_nxt;
      taken_r <= taken_nxt;
    end
  end

  // Outputs come straight from registers, except data_wdata_o, which is the constant CLEAR_VALUE.
  assign pc_o = pc_r;
  assign quarter_o = quarter;
  assign stack_push_o = push_r;
  assign top_of_stack_o = ret_top_r;
  assign working_shadow_o = wsh_r;
  assign status_shadow_o = ss_r;
  assign bank_select_shadow_o = bs_r;
  assign data_rd_o = rd_r;
  assign data_wr_o = wr_r;
  assign data_addr_o = addr_r;
  assign data_wdata_o = CLEAR_VALUE;
  assign zero_set_o = zset_r;
  assign indexed_mode_o = idx_r;
endmodule : bcce_core

// file: rtl/bcce_pkg.sv
// Purpose: Constants for the branch, call and clear execute block.
// Assumes: One quarter phase per sys_clk cycle, four quarters per instruction cycle.
// Notes: Encodings, ACCESS_BIT, SHADOW_BIT and PC_RESET live here; other field slices and reset values are literals in the core.
package bcce_pkg;
  localparam int PC_W = 21;
  localparam int DADDR_W = 12;
  localparam logic [7:0] OPC_BRANCH_ZERO = 8'he0;
  localparam logic [7:0] OPC_BRANCH_OVF = 8'he4;
  localparam logic [6:0] OPC_CALL = 7'h76;
  localparam logic [3:0] OPC_CALL_WORD2 = 4'hf;
  localparam logic [6:0] OPC_CLEAR = 7'h35;
  localparam int SHADOW_BIT = 8;
  localparam int ACCESS_BIT = 8;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] CALL_RET_STEP = 21'h000004;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [7:0] INDEXED_MAX = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [7:0] CLEAR_VALUE = 8'h00;
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_NOP = 1'b1
  } bcce_state_t;
  typedef enum logic [2:0] {
    OP_OTHER = 3'b000,
    OP_BRZ = 3'b001,
    OP_BROV = 3'b010,
    OP_CALL = 3'b011,
    OP_CLEAR = 3'b100
  } bcce_op_t;
endpackage : bcce_pkg

// file: rtl/bcce_qphase.sv
// Purpose: Quarter phase sequencer for the instruction cycle.
// Assumes: Each sys_clk cycle is one quarter phase.
// Notes: Q1 follows reset release.
`timescale 1ns/1ps
module bcce_qphase
  import bcce_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Current quarter, Q1 to Q4.
  output logic [1:0] quarter_o
);
  logic [1:0] quarter_r; // Registered quarter count.
  logic [1:0] quarter_nxt; // Next quarter count.

  // Advance one quarter every clock and wrap after Q4.
  always_comb begin
    quarter_nxt = quarter_r + 2'h1;
  end

  // Register the quarter; reset starts a fresh cycle at Q1.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      quarter_r <= Q1;
    end else begin
      quarter_r <= quarter_nxt;
    end
  end

  assign quarter_o = quarter_r;
endmodule : bcce_qphase

// file: dv/bcce_core_assertions.sv
// Purpose: Timing checks on the execute block ports.
// Assumes: One clock is one quarter phase.
// Notes: Bound into every bcce_core.
`timescale 1ns/1ps
module bcce_core_chk
  import bcce_pkg::*;
(
  // Watched ports.
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic [1:0] quarter_o,
  input wire logic stack_push_o,
  input wire logic [PC_W-1:0] top_of_stack_o,
  input wire logic [7:0] working_shadow_o,
  input wire logic data_rd_o,
  input wire logic data_wr_o,
  input wire logic [DADDR_W-1:0] data_addr_o,
  input wire logic zero_set_o
);
  // One domain, so clock and reset are given once.
  default clocking dcb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_push_in_q4: assert property (stack_push_o |-> quarter_o == Q4)
    else $error("push not in Q4");
  a_push_ret_addr: assert property (stack_push_o |-> top_of_stack_o == pc_o + CALL_RET_STEP)
    else $error("bad return address");
  a_call_nop_hold: assert property (stack_push_o |=> ##1 $stable(pc_o) [*3])
    else $error("pc moved in idle cycle");
  a_pc_at_q1: assert property ($changed(pc_o) |-> quarter_o == Q1)
    else $error("pc moved mid cycle");
  a_shadow_on_push: assert property ($changed(working_shadow_o) |-> stack_push_o)
    else $error("shadow moved without call");
  a_read_in_q3: assert property (data_rd_o |-> quarter_o == Q3)
    else $error("read not in Q3");
  a_write_follows: assert property (data_rd_o |-> ##2 data_wr_o && zero_set_o)
    else $error("write or zero set missing");
  a_addr_held: assert property (data_rd_o |=> $stable(data_addr_o) [*2])
    else $error("address moved before write");
endmodule : bcce_core_chk
bind bcce_core bcce_core_chk u_chk (.sys_clk_i, .sys_rst_i, .pc_o, .quarter_o, .stack_push_o,
  .top_of_stack_o, .working_shadow_o, .data_rd_o, .data_wr_o, .data_addr_o, .zero_set_o);

// file: dv/bcce_progmem.sv
// Purpose: Program memory model for the execute block.
// Assumes: Words are indexed by pc bits 20:1.
// Notes: Unwritten words read as zero, a plain advancing opcode.
`timescale 1ns/1ps
module bcce_progmem
  import bcce_pkg::*;
(
  // Counter from the core, load port from the bench.
  input wire logic [PC_W-1:0] pc_i,
  input wire logic load_i,
  input wire logic [19:0] load_addr_i,
  input wire logic [15:0] load_word_i,
  // Words shown with no wait state.
  output logic [15:0] instr_word_o,
  output logic [15:0] call_word2_o
);
  // Sparse store, because call targets span the whole space.
  logic [15:0] rom [logic [19:0]];
  // Words follow the counter; a load refreshes them as well.
  always @(pc_i or load_i) begin
    if (load_i) rom[load_addr_i] = load_word_i;
    instr_word_o = rom.exists(pc_i[20:1]) ? rom[pc_i[20:1]] : 16'h0000;
    call_word2_o = rom.exists(pc_i[20:1] + 20'h1) ? rom[pc_i[20:1] + 20'h1] : 16'h0000;
  end
endmodule : bcce_progmem

// file: dv/tb.sv
// Purpose: Random self-checking run of the execute block.
// Assumes: Inputs change at the falling edge.
// Notes: A reference model predicts every result.
`timescale 1ns/1ps
module tb;
  import bcce_pkg::*;
  int num_errors = 0, total_checks = 0;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, zf = 1'b0, vf = 1'b0, ext = 1'b0, load = 1'b0;
  logic [7:0] w = 8'h00, st = 8'h00, bank_sel = 8'h00, wshad, ss, bs, wd;
  logic [DADDR_W-1:0] ib = 12'h000, da;
  logic [19:0] la = 20'h00000;
  logic [15:0] lw = 16'h0000, iw0, iw1;
  logic [31:0] seed = 32'h2e;
  logic [PC_W-1:0] pc, ret_top, epc = 21'h000000;
  logic [PC_W-1:0] ret_q[$]; // Expected return stack, newest entry last.
  logic [1:0] qtr;
  logic push, rd, wr, zs, idx;
  logic [23:0] esh = 24'h000000;
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end
  always #12.5 sys_clk_i = ~sys_clk_i;
  bcce_progmem mem (.pc_i(pc), .load_i(load), .load_addr_i(la), .load_word_i(lw), .instr_word_o(iw0),
    .call_word2_o(iw1));
  bcce_core dut (.sys_clk_i, .sys_rst_i, .instr_word_i(iw0), .call_word2_i(iw1), .pc_o(pc), .quarter_o(qtr),
    .zero_flag_i(zf), .overflow_flag_i(vf), .working_i(w), .status_i(st), .bank_select_register_i(bank_sel),
    .extended_set_i(ext), .index_base_i(ib), .stack_push_o(push), .top_of_stack_o(ret_top),
    .working_shadow_o(wshad), .status_shadow_o(ss), .bank_select_shadow_o(bs), .data_rd_o(rd), .data_wr_o(wr),
    .data_addr_o(da), .data_wdata_o(wd), .zero_set_o(zs), .indexed_mode_o(idx));
  // Xorshift source, seeded for a repeatable run.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Loads one word; the gaps keep each load edge visible.
  task automatic put(input logic [19:0] a, input logic [15:0] d);
    la = a;
    lw = d;
    load = 1'b1;
    #1 load = 1'b0;
    #1;
  endtask : put
  // One random instruction, checked quarter by quarter.
  task automatic step();
    logic [31:0] r, q;
    logic [15:0] iw;
    logic [7:0] f;
    logic [11:0] ea;
    logic [2:0] kind;
    logic jump;
    r = rnd();
    q = rnd();
    kind = 3'(r[7:0] % 5);
    f = r[31:30] == 2'b00 ? (r[29] ? INDEXED_MAX : 8'h60) : r[15:8];
    {zf, vf, ext, w, st, bank_sel, ib} = {q[2:0], q[15:8], q[23:16], q[31:24], q[27:16]};
    case (kind)
      3'd0: iw = {OPC_BRANCH_ZERO, f};
      3'd1: iw = {OPC_BRANCH_OVF, f};
      3'd2: iw = {OPC_CALL, r[16], f};
      3'd3: iw = {OPC_CLEAR, r[16], f};
      default: iw = {4'h0, r[27:16]};
    endcase
    jump = (kind == 0 && zf) || (kind == 1 && vf);
    `CHK(qtr, Q1)
    put(epc[20:1], iw);
    put(epc[20:1] + 20'h1, {OPC_CALL_WORD2, q[11:0]});
    repeat (2) @(negedge sys_clk_i);
    `CHK(rd, kind == 3)
    if (r[16]) ea = {bank_sel[3:0], f};
    else if (ext && f <= INDEXED_MAX) ea = ib + {4'h0, f};
    else ea = {f[7] ? ACCESS_HIGH_BANK : 4'h0, f};
    if (kind == 3) begin
      `CHK(da, ea)
      `CHK(idx, !r[16] && ext && f <= INDEXED_MAX)
    end
    @(negedge sys_clk_i);
    `CHK(push, kind == 2)
    if (kind == 2 && r[16]) esh = {w, st, bank_sel};
    `CHK({wshad, ss, bs}, esh)
    // The stack top must hold its last pushed value across every later instruction.
    if (kind == 2) ret_q.push_back(epc + CALL_RET_STEP);
    if (ret_q.size() > 0) `CHK(ret_top, ret_q[$])
    if (kind == 2) epc = {q[11:0], f, 1'b0};
    else if (jump) epc = epc + PC_STEP + {{12{f[7]}}, f, 1'b0};
    else epc = epc + PC_STEP;
    @(negedge sys_clk_i);
    `CHK(pc, epc)
    `CHK({wr, zs}, {2{kind == 3}})
    if (kind == 3) `CHK(wd, 8'h00)
    if (jump || kind == 2) begin
      // A clear shown at the target during the idle cycle must not act.
      put(epc[20:1], {OPC_CLEAR, 1'b1, f});
      repeat (2) @(negedge sys_clk_i);
      `CHK(rd, 1'b0)
      repeat (2) @(negedge sys_clk_i);
      `CHK(pc, epc)
      `CHK({wr, zs}, 2'b00)
    end
  endtask : step
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (6) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 400; i++) step();
    $display("test random_mix done");
    complete_run();
  end
endmodule : tb
